// file: src/qdsc_front_end.sv
/*
 * Serial command front end of a quad 8-bit converter: the link-side shift
 * register and serial output on the serial clock, and the command decoder,
 * input registers and converter registers on the system clock.
 * Chip select high gates the shift register, even with the serial clock running,
 * so the shift register is quiet whenever the system clock reads it.
 */
`timescale 1ns/1ps

module qdsc_front_end #(
    parameter int WORD_W = qdsc_pkg::WORD_BITS,
    parameter int DATA_W = qdsc_pkg::DATA_BITS
) (
    // System clock and synchronous power-up reset.
    input wire logic clk,
    input wire logic rst,
    // Serial link from the host.
    input wire logic serial_clk,
    input wire logic chip_select_n,
    input wire logic serial_in,
    output logic serial_out,
    // Asynchronous control pins.
    input wire logic load_outputs_n,
    input wire logic clear_all_n,
    // Input register contents, one per channel.
    output logic [DATA_W-1:0] input_reg_a,
    output logic [DATA_W-1:0] input_reg_b,
    output logic [DATA_W-1:0] input_reg_c,
    output logic [DATA_W-1:0] input_reg_d,
    // Converter register contents, one per channel.
    output logic [DATA_W-1:0] dac_reg_a,
    output logic [DATA_W-1:0] dac_reg_b,
    output logic [DATA_W-1:0] dac_reg_c,
    output logic [DATA_W-1:0] dac_reg_d,
    // Status.
    output logic out_rising_mode,
    output logic command_done
);
    import qdsc_pkg::*;

    // Link-domain state.
    logic [WORD_W-1:0] shift_q;
    logic out_rise_q;
    logic out_fall_q;
    logic link_rst;

    // System-domain state.
    logic cs_n_sync;
    logic cs_n_prev_q;
    logic load_n_sync;
    logic cs_rise;
    logic mode_rising_q;
    logic done_q;
    logic [DATA_W-1:0] input_q [CHANNELS];
    logic [DATA_W-1:0] dac_q [CHANNELS];
    logic [DATA_W-1:0] input_d [CHANNELS];
    logic [DATA_W-1:0] dac_d [CHANNELS];
    logic [1:0] clear_hold_q;
    logic clear_n;

    // Decoded command fields.
    logic [WORD_W-1:0] word;
    logic [ADDR_BITS-1:0] chan;
    logic [DATA_W-1:0] data;
    qdsc_action_type action;

    // Picks the action of one word from its address and control bits.
    // Every code has a meaning, so the case needs no default; the mode
    // words fall under the copy action and set the edge separately.
    function automatic qdsc_action_type decode_action(
        input logic [WORD_W-1:0] w
    );
        logic [1:0] code;
        code = {w[CMD_HI_POS], w[CMD_LO_POS]};
        unique case (code)
            CMD_LOAD_INPUT: begin
                decode_action = ACT_LOAD_INPUT;
            end
            CMD_LOAD_BOTH: begin
                decode_action = ACT_LOAD_BOTH;
            end
            CMD_BROADCAST_OR_NOP: begin
                // Low address bit set means pass-through only.
                if (w[ADDR_LO_POS]) begin
                    decode_action = ACT_NONE;
                end else begin
                    decode_action = ACT_BROADCAST;
                end
            end
            CMD_COPY_OR_MODE: begin
                decode_action = ACT_COPY_ALL;
            end
        endcase
    endfunction : decode_action

    // True when a word sets the output edge mode, whichever edge it picks.
    // The low address bit of such a word then picks rising or falling.
    function automatic logic is_mode_word(input logic [WORD_W-1:0] w);
        is_mode_word = ({w[CMD_HI_POS], w[CMD_LO_POS]} == CMD_COPY_OR_MODE)
            && w[ADDR_HI_POS];
    endfunction : is_mode_word

    // True when a decoded command addresses channel idx.
    function automatic logic hits_channel(
        input logic [ADDR_BITS-1:0] sel,
        input int idx
    );
        hits_channel = (sel == ADDR_BITS'(idx));
    endfunction : hits_channel

    // Power-up reset carried into the link domain; it needs link edges.
    // The host must toggle the serial clock a few times during reset,
    // or the link flops keep whatever they woke up with.
    qdsc_sync #(
        .WIDTH(1),
        .RESET_VAL(1'b0)
    ) u_link_rst (
        .clk(serial_clk),
        .rst(1'b0),
        .level_in(rst),
        .level_out(link_rst)
    );

    // Chip select into the system domain; idles deselected.
    // Its rise, seen two edges late, is what starts a command.
    qdsc_sync #(
        .WIDTH(1),
        .RESET_VAL(1'b1)
    ) u_cs_sync (
        .clk(clk),
        .rst(rst),
        .level_in(chip_select_n),
        .level_out(cs_n_sync)
    );

    // Load pin into the system domain; idles inactive.
    // Following the pin therefore lags it by two or three clk cycles.
    qdsc_sync #(
        .WIDTH(1),
        .RESET_VAL(1'b1)
    ) u_load_sync (
        .clk(clk),
        .rst(rst),
        .level_in(load_outputs_n),
        .level_out(load_n_sync)
    );

    // Clear pin: asserts at once, releases only after two clk edges.
    // A bare release close to an edge could leave some channels cleared
    // and others written; the two stages make the release clean.
    always_ff @(posedge clk or negedge clear_all_n) begin
        if (!clear_all_n) begin
            clear_hold_q <= '0;
        end else begin
            clear_hold_q <= {clear_hold_q[0], 1'b1};
        end
    end
    assign clear_n = clear_hold_q[1];

    // Shift register: takes one bit per rising edge while selected.
    // Longer frames push the oldest bits out of the top, so the last
    // twelve bits sent are always the ones that get decoded.
    always_ff @(posedge serial_clk) begin
        if (link_rst) begin
            shift_q <= WORD_ZERO;
        end else if (!chip_select_n) begin
            shift_q <= {shift_q[WORD_W-2:0], serial_in};
        end
    end

    // Rising-edge output stage; the top bit one edge later lags twelve.
    // It feeds the next device of a chain through its data input.
    always_ff @(posedge serial_clk) begin
        if (link_rst) begin
            out_rise_q <= 1'b0;
        end else if (!chip_select_n) begin
            out_rise_q <= shift_q[WORD_W-1];
        end
    end

    // Falling-edge stage adds half a cycle to the rising stage.
    // That extra half cycle gives a host sampling on rises more margin.
    always_ff @(negedge serial_clk) begin
        if (link_rst) begin
            out_fall_q <= 1'b0;
        end else if (!chip_select_n) begin
            out_fall_q <= out_rise_q;
        end
    end

    // Both stages hold while deselected, so the pin is always driven.
    // A mode word flips the selector while deselected, so the pin may
    // step once then; hosts read it only while they clock a frame.
    assign serial_out = mode_rising_q ? out_rise_q : out_fall_q;

    // Chip select rise marks the only moment a command executes.
    assign cs_rise = cs_n_sync && !cs_n_prev_q;

    // Previous synchronised select level for the edge detector; it
    // resets deselected so that leaving reset makes no false edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_n_prev_q <= 1'b1;
        end else begin
            cs_n_prev_q <= cs_n_sync;
        end
    end

    // The link is quiet after select rises, so the word is stable here.
    // This rests on chip select gating the shift register between
    // frames; a clock running while deselected is ignored.
    assign word = shift_q;
    assign chan = {word[ADDR_HI_POS], word[ADDR_LO_POS]};
    assign data = word[DATA_MSB_POS:DATA_LSB_POS];
    assign action = cs_rise ? decode_action(word) : ACT_NONE;

    // Output edge mode; only power-up or a mode word changes it.
    // The clear pin does not reach it, so a cleared chain keeps timing.
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_rising_q <= MODE_RISING;
        end else if (cs_rise && is_mode_word(word)) begin
            if (word[ADDR_LO_POS]) begin
                mode_rising_q <= MODE_RISING;
            end else begin
                mode_rising_q <= MODE_FALLING;
            end
        end
    end

    // Next input register values; only the two load commands write them,
    // and each writes the single channel that its address bits pick.
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            input_d[i] = input_q[i];
            if ((action == ACT_LOAD_INPUT || action == ACT_LOAD_BOTH)
                    && hits_channel(chan, i)) begin
                input_d[i] = data;
            end
        end
    end

    // Input registers: the clear wins over any write at once.
    always_ff @(posedge clk or negedge clear_n) begin
        if (!clear_n) begin
            for (int i = 0; i < CHANNELS; i++) begin
                input_q[i] <= CODE_ZERO;
            end
        end else if (rst) begin
            for (int i = 0; i < CHANNELS; i++) begin
                input_q[i] <= CODE_ZERO;
            end
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                input_q[i] <= input_d[i];
            end
        end
    end

    // Next converter values. A broadcast, copy or load-both write beats the load pin in one cycle;
    // with the pin low and no command the converters track the inputs.
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            dac_d[i] = dac_q[i];
            if (action == ACT_BROADCAST) begin
                dac_d[i] = data;
            end else if (action == ACT_COPY_ALL) begin
                dac_d[i] = input_q[i];
            end else if (action == ACT_LOAD_BOTH
                    && hits_channel(chan, i)) begin
                dac_d[i] = data;
            end else if (!load_n_sync) begin
                dac_d[i] = input_q[i];
            end
        end
    end

    // Converter registers: the clear wins, as for the input registers.
    always_ff @(posedge clk or negedge clear_n) begin
        if (!clear_n) begin
            for (int i = 0; i < CHANNELS; i++) begin
                dac_q[i] <= CODE_ZERO;
            end
        end else if (rst) begin
            for (int i = 0; i < CHANNELS; i++) begin
                dac_q[i] <= CODE_ZERO;
            end
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                dac_q[i] <= dac_d[i];
            end
        end
    end

    // One-cycle pulse after any command word, a no-operation included.
    // It rises on the same edge as the registers take their new values.
    always_ff @(posedge clk) begin
        if (rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= cs_rise;
        end
    end

    // Register contents out to the converter ladders.
    // All of them come straight from flops, so the ladders see no glitch.
    assign input_reg_a = input_q[0];
    assign input_reg_b = input_q[1];
    assign input_reg_c = input_q[2];
    assign input_reg_d = input_q[3];
    assign dac_reg_a = dac_q[0];
    assign dac_reg_b = dac_q[1];
    assign dac_reg_c = dac_q[2];
    assign dac_reg_d = dac_q[3];
    assign out_rising_mode = mode_rising_q;
    assign command_done = done_q;
endmodule : qdsc_front_end

// file: src/qdsc_sync.sv
/*
 * Shared constants of the quad converter serial command front end, and a
 * two-stage level synchroniser used for the reset, chip select and load pin crossings.
 * Assumes the synchronised levels change slowly against the sampling clock.
 */
package qdsc_pkg;
    localparam int WORD_BITS = 12;
    localparam int DATA_BITS = 8;
    localparam int CHANNELS = 4;
    localparam int ADDR_BITS = 2;
    // Field positions inside the 12-bit command word, first bit sent on top.
    localparam int ADDR_HI_POS = 11;
    localparam int ADDR_LO_POS = 10;
    localparam int CMD_HI_POS = 9;
    localparam int CMD_LO_POS = 8;
    localparam int DATA_MSB_POS = 7;
    localparam int DATA_LSB_POS = 0;
    // Two-bit control codes.
    localparam logic [1:0] CMD_BROADCAST_OR_NOP = 2'h0;
    localparam logic [1:0] CMD_LOAD_INPUT = 2'h1;
    localparam logic [1:0] CMD_COPY_OR_MODE = 2'h2;
    localparam logic [1:0] CMD_LOAD_BOTH = 2'h3;
    // Reset values.
    localparam logic [DATA_BITS-1:0] CODE_ZERO = 8'h00;
    localparam logic [WORD_BITS-1:0] WORD_ZERO = 12'h000;
    localparam logic MODE_RISING = 1'b1;
    localparam logic MODE_FALLING = 1'b0;
    // Decoded action of one command word.
    typedef enum {
        ACT_NONE,
        ACT_LOAD_INPUT,
        ACT_LOAD_BOTH,
        ACT_BROADCAST,
        ACT_COPY_ALL
    } qdsc_action_type;
endpackage : qdsc_pkg

`timescale 1ns/1ps

module qdsc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and synchronous reset of the receiving domain.
    input wire logic clk,
    input wire logic rst,
    // Asynchronous level in, synchronised level out.
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] meta_q;

    // Two flops; only the second stage reads the first.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            level_out <= RESET_VAL;
        end else begin
            meta_q <= level_in;
            level_out <= meta_q;
        end
    end
endmodule : qdsc_sync

// file: test/qdsc_front_end_sva.sv
/* Checker of the front end ports, all sampled on the system clock.
   Assumes it is bound into every qdsc_front_end instance. */
`timescale 1ns/1ps
module qdsc_front_end_sva #(
    parameter int DATA_W = 8
) (
    // Clock, reset and link select.
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic serial_out,
    // Control pins and register contents.
    input wire logic load_outputs_n,
    input wire logic clear_all_n,
    input wire logic [DATA_W-1:0] input_reg_a,
    input wire logic [DATA_W-1:0] dac_reg_a,
    input wire logic out_rising_mode,
    input wire logic command_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A select rise starts a command; the load window holds input steady.
    sequence sel_rise;
        $rose(chip_select_n);
    endsequence
    sequence load_win;
        (!load_outputs_n && clear_all_n && $stable(input_reg_a))[*5];
    endsequence
    chk_reset_state: assert property (
        $fell(rst) |-> input_reg_a == '0 && dac_reg_a == '0 && out_rising_mode)
        else $error("state after reset not cleared");
    chk_clear_zero: assert property (
        !clear_all_n |-> input_reg_a == '0 && dac_reg_a == '0)
        else $error("clear pin left a register set");
    chk_clear_mode: assert property (
        !clear_all_n |=> $stable(out_rising_mode))
        else $error("clear pin changed output edge mode");
    chk_done_late: assert property (
        sel_rise |-> !command_done ##1 !command_done)
        else $error("command finished too soon after select rise");
    chk_done_desel: assert property (
        command_done |-> chip_select_n && $past(chip_select_n, 3))
        else $error("command finished while selected");
    chk_done_pulse: assert property (
        command_done |=> !command_done)
        else $error("done pulse longer than one cycle");
    chk_mode_cmd: assert property (
        $changed(out_rising_mode) |-> command_done)
        else $error("edge mode changed without a command");
    chk_quiet_regs: assert property (
        !chip_select_n && $past(!chip_select_n) && load_outputs_n &&
        clear_all_n |=> $stable(dac_reg_a) && $stable(input_reg_a))
        else $error("register changed during shifting");
    chk_sout_hold: assert property (
        chip_select_n && $past(chip_select_n) && $stable(out_rising_mode)
        |-> $stable(serial_out))
        else $error("serial output moved while deselected");
    chk_load_follow: assert property (
        load_win |-> dac_reg_a == input_reg_a)
        else $error("converter register not following input");
endmodule : qdsc_front_end_sva

bind qdsc_front_end qdsc_front_end_sva #(.DATA_W(DATA_W)) chk (
    .clk(clk), .rst(rst), .chip_select_n(chip_select_n),
    .serial_out(serial_out), .load_outputs_n(load_outputs_n),
    .clear_all_n(clear_all_n), .input_reg_a(input_reg_a),
    .dac_reg_a(dac_reg_a), .out_rising_mode(out_rising_mode),
    .command_done(command_done));

// file: test/qdsc_host_model.sv
/* Host model that drives the serial link of the front end.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module qdsc_host_model (
    // Link outputs to the device.
    output logic serial_clk,
    output logic chip_select_n,
    output logic serial_in,
    // Device serial output, captured while the clock is high.
    input wire logic serial_out
);
    logic [23:0] rx_q;
    // The link rests deselected with the clock low.
    initial begin
        serial_clk = 1'b0;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
        rx_q = '0;
    end
    // Clock edges with select high, used only while reset settles.
    task idle_edges(input int n);
        repeat (n) begin
            #3 serial_clk = 1'b1;
            #3 serial_clk = 1'b0;
        end
    endtask : idle_edges
    // One frame, top bit first; the clock stands low outside it.
    task send(input logic [23:0] w, input int n);
        chip_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = w[i];
            #3 serial_clk = 1'b1;
            #1 rx_q = {rx_q[22:0], serial_out};
            #2 serial_clk = 1'b0;
        end
        #3 chip_select_n = 1'b1;
        serial_in = ~serial_in;
    endtask : send
endmodule : qdsc_host_model

// file: test/qdsc_front_end_test.sv
/* Bench of the front end: the host model sends frames, the bench checks
   registers and the serial output. Assumes the checker is bound. */
`timescale 1ns/1ps
module qdsc_front_end_test;
    import qdsc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic load_outputs_n = 1'b1;
    logic clear_all_n = 1'b1;
    logic serial_clk, chip_select_n, serial_in, serial_out;
    logic out_rising_mode, command_done;
    logic [7:0] in_a, in_b, in_c, in_d, dac_a, dac_b, dac_c, dac_d;
    logic [7:0] ins [4];
    logic [7:0] dacs [4];
    logic [7:0] vals [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    int n_fail = 0;
    int checks = 0;
    // Clock and channel views.
    always #4 clk = ~clk;
    always_comb ins = '{in_a, in_b, in_c, in_d};
    always_comb dacs = '{dac_a, dac_b, dac_c, dac_d};
    qdsc_host_model host (.serial_clk(serial_clk),
        .chip_select_n(chip_select_n), .serial_in(serial_in),
        .serial_out(serial_out));
    qdsc_front_end dut (.clk(clk), .rst(rst), .serial_clk(serial_clk),
        .chip_select_n(chip_select_n), .serial_in(serial_in),
        .serial_out(serial_out), .load_outputs_n(load_outputs_n),
        .clear_all_n(clear_all_n), .input_reg_a(in_a), .input_reg_b(in_b),
        .input_reg_c(in_c), .input_reg_d(in_d), .dac_reg_a(dac_a),
        .dac_reg_b(dac_b), .dac_reg_c(dac_c), .dac_reg_d(dac_d),
        .out_rising_mode(out_rising_mode), .command_done(command_done));
    // Compares one value and counts it.
    task chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Sends a frame and waits past the fixed execution latency.
    task cmd(input logic [23:0] w, input int n);
        host.send(w, n);
        repeat (10) @(posedge clk);
    endtask : cmd
    // Prints the counts and the verdict, then ends the run.
    task test_done;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // Cuts a hang short.
    initial begin
        #100000;
        n_fail++;
        test_done();
    end
    // Main sequence of tests.
    initial begin
        host.idle_edges(4);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        host.idle_edges(3);
        @(posedge clk);
        chk({11'h0, out_rising_mode}, 12'h001);
        for (int i = 0; i < 4; i++) begin
            chk({4'h0, ins[i]}, 12'h000);
            chk({4'h0, dacs[i]}, 12'h000);
        end
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            cmd({8'h00, 4'hF, 2'(i), CMD_LOAD_INPUT, vals[i]},
                16 - 4 * (i > 0));
            chk({4'h0, ins[i]}, {4'h0, vals[i]});
            chk({4'h0, dacs[i]}, 12'h000);
        end
        cmd({12'h0, 2'h0, CMD_COPY_OR_MODE, 8'hFF}, 12);
        for (int i = 0; i < 4; i++)
            chk({4'h0, dacs[i]}, {4'h0, vals[i]});
        cmd({12'h0, 2'h2, CMD_LOAD_BOTH, 8'h5A}, 12);
        chk({4'h0, ins[2]}, 12'h05A);
        chk({4'h0, dacs[2]}, 12'h05A);
        chk({4'h0, dacs[1]}, 12'h022);
        $display("load test done");
        cmd({12'h0, 2'h1, CMD_BROADCAST_OR_NOP, 8'hEE}, 12);
        chk({4'h0, dacs[0]}, 12'h011);
        chk({4'h0, ins[3]}, 12'h044);
        cmd({12'h0, 2'h2, CMD_BROADCAST_OR_NOP, 8'hA5}, 12);
        for (int i = 0; i < 4; i++)
            chk({4'h0, dacs[i]}, 12'h0A5);
        chk({4'h0, ins[0]}, 12'h011);
        $display("broadcast test done");
        cmd({12'h9A6, 12'h400}, 24);
        chk(host.rx_q[11:0], 12'h9A6);
        chk({4'h0, ins[2]}, 12'h05A);
        cmd({12'h0, 12'hA00}, 12);
        chk({11'h0, out_rising_mode}, 12'h000);
        chk({4'h0, dacs[0]}, 12'h011);
        cmd({12'h9A6, 12'h400}, 24);
        chk({1'b0, host.rx_q[10:0]}, 12'h4D3);
        clear_all_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk({4'h0, dacs[0]}, 12'h000);
        chk({4'h0, ins[1]}, 12'h000);
        chk({11'h0, out_rising_mode}, 12'h000);
        clear_all_n <= 1'b1;
        cmd({12'h0, 12'hE00}, 12);
        chk({11'h0, out_rising_mode}, 12'h001);
        $display("serial output test done");
        load_outputs_n <= 1'b0;
        cmd({12'h0, 2'h0, CMD_LOAD_INPUT, 8'h77}, 12);
        chk({4'h0, dacs[0]}, 12'h077);
        load_outputs_n <= 1'b1;
        $display("load pin test done");
        test_done();
    end
endmodule : qdsc_front_end_test
